// ### verilog/spi_register_host.v
`timescale 1ns/10ps
`default_nettype none
`include "spi_host_defs.vh"
module spi_register_host
#(
    parameter GAP_CYCLES = `GAP_CYCLES
)
(
    input  wire         clk_i,
    input  wire         reset_n_i,
    input  wire         start_i,
    input  wire [7:0]   command_i,
    input  wire [7:0]   command_argument_byte_i,
    input  wire [4:0]   request_len_i,
    input  wire [4:0]   response_len_i,
    input  wire [127:0] write_data_i,
    input  wire         spi_miso_i,
    output reg          spi_sck_o,
    output reg          spi_cs_n_o,
    output reg          spi_mosi_o,
    output reg          busy_o,
    output reg          done_o,
    output reg  [7:0]   echo_command_o,
    output reg  [7:0]   echo_argument_o,
    output reg  [7:0]   response_error_code_o,
    output reg  [127:0] read_data_o,
    output reg  [7:0]   previous_error_code_o
);

////////////////////////////////////////////////////////////////////////////////
// reset release and miso synchroniser

reg        rst_meta;
reg        rst_n;
reg  [2:0] miso_sync;
reg        miso_clean;

always @(posedge clk_i or negedge reset_n_i)
begin
    if (!reset_n_i)
    begin
        rst_meta <= 1'b0;
        rst_n    <= 1'b0;
    end
    else
    begin
        rst_meta <= 1'b1;
        rst_n    <= rst_meta;
    end
end

// miso may float between packets, so it is filtered like a pin
always @(posedge clk_i or negedge rst_n)
begin
    if (!rst_n)
    begin
        miso_sync  <= 3'h0;
        miso_clean <= 1'b0;
    end
    else
    begin
        miso_sync <= {miso_sync[1:0], spi_miso_i};
        if (miso_sync[1] == miso_sync[2])
        begin
            miso_clean <= miso_sync[2];
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// byte shifter

localparam [2:0] ST_IDLE   = 3'd0;
localparam [2:0] ST_SETUP  = 3'd1;
localparam [2:0] ST_SHIFT  = 3'd2;
localparam [2:0] ST_WAIT   = 3'd3;
localparam [2:0] ST_HOLD   = 3'd4;
localparam [2:0] ST_GAP    = 3'd5;

reg  [2:0]   state;
reg          phase_resp;
reg  [4:0]   byte_idx;
reg  [4:0]   pkt_len;
reg  [3:0]   setup_cnt;
reg  [15:0]  gap_cnt;
reg          byte_start;
reg  [7:0]   tx_byte;
reg  [7:0]   cmd_q;
reg  [7:0]   arg_q;
reg  [4:0]   resp_len_q;
reg  [127:0] wdata_q;
wire         sh_sck;
wire         sh_mosi;
wire [7:0]   sh_rx;
wire         sh_done;

spi_bit_shifter u_shifter
(
    .clk_i     (clk_i),
    .rst_n_i   (rst_n),
    .start_i   (byte_start),
    .tx_byte_i (tx_byte),
    .miso_i    (miso_clean),
    .sck_o     (sh_sck),
    .mosi_o    (sh_mosi),
    .rx_byte_o (sh_rx),
    .done_o    (sh_done)
);

// byte i of a payload, least significant byte first
function [7:0] payload_byte;
    input [127:0] data;
    input [4:0]   idx;
    begin
        payload_byte = data[{idx[3:0], 3'b000} +: 8];
    end
endfunction

// request byte to send for a given position
function [7:0] request_byte;
    input [7:0]   cmd;
    input [7:0]   arg;
    input [127:0] data;
    input [4:0]   idx;
    begin
        if (idx == 5'd0)
            request_byte = cmd;
        else if (idx == 5'd1)
            request_byte = arg;
        else if (idx < `HEADER_BYTES)
            request_byte = 8'h00;
        else
            request_byte = payload_byte(data, idx - `HEADER_BYTES);
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// transaction sequencer

always @(posedge clk_i or negedge rst_n)
begin
    if (!rst_n)
    begin
        state                 <= ST_IDLE;
        phase_resp            <= 1'b0;
        byte_idx              <= 5'd0;
        pkt_len               <= 5'd0;
        setup_cnt             <= 4'h0;
        gap_cnt               <= 16'h0000;
        byte_start            <= 1'b0;
        tx_byte               <= 8'h00;
        cmd_q                 <= 8'h00;
        arg_q                 <= 8'h00;
        resp_len_q            <= 5'd0;
        wdata_q               <= 128'h0;
        spi_cs_n_o            <= 1'b1;
        spi_sck_o             <= 1'b1;
        spi_mosi_o            <= 1'b0;
        busy_o                <= 1'b0;
        done_o                <= 1'b0;
        echo_command_o        <= 8'h00;
        echo_argument_o       <= 8'h00;
        response_error_code_o <= 8'h00;
        read_data_o           <= 128'h0;
        previous_error_code_o <= 8'h00;
    end
    else
    begin
        byte_start <= 1'b0;
        done_o     <= 1'b0;
        spi_sck_o  <= sh_sck;
        spi_mosi_o <= sh_mosi;
        case (state)
        ST_IDLE:
        begin
            spi_cs_n_o <= 1'b1;
            if (start_i)
            begin
                cmd_q      <= command_i;
                arg_q      <= command_argument_byte_i;
                wdata_q    <= write_data_i;
                // a read carries the header only
                if (command_i == `CMD_READ_REG)
                    pkt_len <= `HEADER_BYTES;
                else if (request_len_i < `HEADER_BYTES)
                    pkt_len <= `HEADER_BYTES;
                else if (request_len_i > `HEADER_BYTES + `MAX_PAYLOAD_BYTES)
                    pkt_len <= `HEADER_BYTES + `MAX_PAYLOAD_BYTES;
                else
                    pkt_len <= request_len_i;
                // response of four bytes is allowed for writes
                if (response_len_i < `HEADER_BYTES)
                    resp_len_q <= `HEADER_BYTES;
                else if (response_len_i > `HEADER_BYTES + `MAX_PAYLOAD_BYTES)
                    resp_len_q <= `HEADER_BYTES + `MAX_PAYLOAD_BYTES;
                else
                    resp_len_q <= response_len_i;
                read_data_o <= 128'h0;
                phase_resp  <= 1'b0;
                busy_o      <= 1'b1;
                state       <= ST_SETUP;
            end
        end
        ST_SETUP:
        begin
            spi_cs_n_o <= 1'b0;
            if (setup_cnt == `SETUP_CYCLES - 4'd1)
            begin
                setup_cnt  <= 4'h0;
                byte_idx   <= 5'd0;
                // response packet clocks zero filler
                tx_byte    <= phase_resp ? 8'h00 : request_byte(cmd_q, arg_q, wdata_q, 5'd0);
                byte_start <= 1'b1;
                state      <= ST_WAIT;
            end
            else
            begin
                setup_cnt <= setup_cnt + 4'd1;
            end
        end
        ST_WAIT:
        begin
            // one cycle so the shifter has taken the start
            state <= ST_SHIFT;
        end
        ST_SHIFT:
        begin
            if (sh_done)
            begin
                if (phase_resp)
                begin
                    // header: zero, command, argument, error code
                    if (byte_idx == 5'd1)
                        echo_command_o <= sh_rx;
                    else if (byte_idx == 5'd2)
                        echo_argument_o <= sh_rx;
                    else if (byte_idx == 5'd3)
                        response_error_code_o <= sh_rx;
                    else if (byte_idx >= `HEADER_BYTES)
                        read_data_o[{byte_idx[3:0] - 4'd4, 3'b000} +: 8] <= sh_rx;
                end
                else if (byte_idx == 5'd3)
                begin
                    // request slot carries the older response
                    previous_error_code_o <= sh_rx;
                end
                if (byte_idx == (phase_resp ? resp_len_q : pkt_len) - 5'd1)
                begin
                    state <= ST_HOLD;
                end
                else
                begin
                    byte_idx   <= byte_idx + 5'd1;
                    tx_byte    <= phase_resp ? 8'h00 :
                                  request_byte(cmd_q, arg_q, wdata_q, byte_idx + 5'd1);
                    byte_start <= 1'b1;
                    state      <= ST_WAIT;
                end
            end
        end
        ST_HOLD:
        begin
            if (setup_cnt == `SETUP_CYCLES - 4'd1)
            begin
                setup_cnt  <= 4'h0;
                spi_cs_n_o <= 1'b1;
                gap_cnt    <= 16'h0000;
                if (phase_resp)
                begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                    state  <= ST_IDLE;
                end
                else
                begin
                    state <= ST_GAP;
                end
            end
            else
            begin
                setup_cnt <= setup_cnt + 4'd1;
            end
        end
        ST_GAP:
        begin
            // device fills its buffer here; cs stays high throughout
            if (gap_cnt == GAP_CYCLES[15:0] - 16'd1)
            begin
                phase_resp <= 1'b1;
                state      <= ST_SETUP;
            end
            else
            begin
                gap_cnt <= gap_cnt + 16'd1;
            end
        end
        default:
        begin
            state <= ST_IDLE;
        end
        endcase
    end
end

endmodule // spi_register_host
`default_nettype wire

// ### shared/spi_host_defs.vh
`ifndef SPI_HOST_DEFS_VH
`define SPI_HOST_DEFS_VH

// command identifiers carried in the first request byte
`define CMD_READ_REG        8'h01
`define CMD_WRITE_REG       8'h02
// error code for a read-only or invalid register
`define ERR_INVALID_REG     8'h08
// header length in bytes
`define HEADER_BYTES        5'd4
// largest payload held, in bytes
`define MAX_PAYLOAD_BYTES   5'd16
`define PAYLOAD_BITS        128
// system clock in MHz
`define CLK_MHZ             125
// least gap between packets, microseconds
`define GAP_US              50
`define GAP_CYCLES          (`GAP_US * `CLK_MHZ)
// link clock half period in system cycles: 125 MHz / 12 = 10.4 Mbps
// miso round trip (sck register, three sync flops, agreement) takes five cycles
`define HALF_PERIOD_CYCLES  4'd6
// select to first clock edge and last edge to select release
`define SETUP_CYCLES        4'd4

`endif

// ### verilog/spi_bit_shifter.v
`timescale 1ns/10ps
`default_nettype none
module spi_bit_shifter
(
    input  wire       clk_i,
    input  wire       rst_n_i,
    input  wire       start_i,
    input  wire [7:0] tx_byte_i,
    input  wire       miso_i,
    output reg        sck_o,
    output reg        mosi_o,
    output reg  [7:0] rx_byte_o,
    output reg        done_o
);

`include "spi_host_defs.vh"

reg        busy;
reg  [3:0] div_cnt;
reg  [2:0] bit_cnt;
reg  [7:0] tx_shift;
reg  [7:0] rx_shift;

// sck idles high; mosi changes on falling, miso sampled on rising
always @(posedge clk_i or negedge rst_n_i)
begin
    if (!rst_n_i)
    begin
        busy      <= 1'b0;
        div_cnt   <= 4'h0;
        bit_cnt   <= 3'h0;
        tx_shift  <= 8'h00;
        rx_shift  <= 8'h00;
        sck_o     <= 1'b1;
        mosi_o    <= 1'b0;
        rx_byte_o <= 8'h00;
        done_o    <= 1'b0;
    end
    else
    begin
        done_o <= 1'b0;
        if (!busy)
        begin
            sck_o <= 1'b1;
            if (start_i)
            begin
                busy     <= 1'b1;
                div_cnt  <= 4'h0;
                bit_cnt  <= 3'h0;
                tx_shift <= tx_byte_i;
            end
        end
        else if (div_cnt != `HALF_PERIOD_CYCLES - 4'd1)
        begin
            div_cnt <= div_cnt + 4'd1;
        end
        else
        begin
            div_cnt <= 4'h0;
            if (sck_o)
            begin
                sck_o    <= 1'b0;
                mosi_o   <= tx_shift[7];
                tx_shift <= {tx_shift[6:0], 1'b0};
            end
            else
            begin
                sck_o    <= 1'b1;
                rx_shift <= {rx_shift[6:0], miso_i};
                bit_cnt  <= bit_cnt + 3'd1;
                if (bit_cnt == 3'd7)
                begin
                    busy      <= 1'b0;
                    done_o    <= 1'b1;
                    rx_byte_o <= {rx_shift[6:0], miso_i};
                end
            end
        end
    end
end

endmodule // spi_bit_shifter
`default_nettype wire

// ### tb/spi_register_host_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module spi_register_host_assertions
#(
    parameter GAP_CYCLES = 20
)
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic start_i,
    input wire logic busy_o,
    input wire logic done_o,
    input wire logic spi_sck_o,
    input wire logic spi_cs_n_o,
    input wire logic spi_mosi_o
);
    logic        in_resp;
    logic [31:0] gap_cnt;
    logic [7:0]  edges;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
////////////////////////////////////////////////
    // in_resp marks the second packet of a transaction
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            in_resp <= 1'b0;
            gap_cnt <= 32'h0000_0000;
            edges   <= 8'h00;
        end
        else
        begin
            if (start_i && !busy_o)
                in_resp <= 1'b0;
            else if ($rose(spi_cs_n_o) && busy_o)
                in_resp <= 1'b1;
            gap_cnt <= spi_cs_n_o ? gap_cnt + 32'h0000_0001 : 32'h0000_0000;
            edges   <= spi_cs_n_o ? 8'h00 : edges + {7'h00, $rose(spi_sck_o)};
        end
    end
////////////////////////////////////////////////
    property p_idle_select;
        !busy_o |-> spi_cs_n_o;
    endproperty
    a_idle_select: assert property (p_idle_select) else $error("select low while idle");
    property p_clock_idle;
        spi_cs_n_o |-> spi_sck_o;
    endproperty
    a_clock_idle: assert property (p_clock_idle) else $error("clock low outside frame");
    property p_launch;
        $rose(spi_sck_o) |-> $stable(spi_mosi_o);
    endproperty
    a_launch: assert property (p_launch) else $error("data moved on rising clock");
    property p_rate;
        $fell(spi_sck_o) |-> !spi_sck_o [*4];
    endproperty
    a_rate: assert property (p_rate) else $error("clock low phase too short");
    property p_bytes;
        $rose(spi_cs_n_o) |-> edges[2:0] == 3'h0 && edges >= 8'd32;
    endproperty
    a_bytes: assert property (p_bytes) else $error("packet not whole header bytes");
    property p_gap;
        $fell(spi_cs_n_o) && in_resp |-> gap_cnt >= GAP_CYCLES;
    endproperty
    a_gap: assert property (p_gap) else $error("gap between packets too short");
    property p_filler;
        in_resp && !spi_cs_n_o && $rose(spi_sck_o) |-> !spi_mosi_o;
    endproperty
    a_filler: assert property (p_filler) else $error("response filler not zero");
    property p_frame_start;
        start_i && !busy_o |=> busy_o ##[1:8] !spi_cs_n_o;
    endproperty
    a_frame_start: assert property (p_frame_start) else $error("no select after start");
    property p_frame_end;
        done_o |-> spi_cs_n_o && spi_sck_o ##1 !done_o;
    endproperty
    a_frame_end: assert property (p_frame_end) else $error("done inside open frame");
endmodule // spi_register_host_assertions

bind spi_register_host spi_register_host_assertions #(.GAP_CYCLES(GAP_CYCLES)) chk_inst
(
    .clk_i(clk_i), .reset_n_i(reset_n_i), .start_i(start_i), .busy_o(busy_o),
    .done_o(done_o), .spi_sck_o(spi_sck_o), .spi_cs_n_o(spi_cs_n_o), .spi_mosi_o(spi_mosi_o)
);
`default_nettype wire

// ### tb/spi_device_model.sv
`timescale 1ns/10ps
`default_nettype none
`include "spi_host_defs.vh"
module spi_device_model
(
    input  wire logic sck_i,
    input  wire logic cs_n_i,
    input  wire logic mosi_i,
    output var  logic miso_o
);
    localparam logic [7:0] ERR_CMD = 8'h04;
    logic [7:0]  rx [20];
    logic [7:0]  tx [20];
    logic [31:0] regs [4];
    logic [7:0]  err;
    logic        out_bit;
    logic        resp;
    int          bits;
    logic        framed;
////////////////////////////////////////////////
    // no pull on the line, so a released output shows the inverse of its last bit
    assign miso_o = cs_n_i ? ~out_bit : out_bit;
    initial
    begin
        foreach (regs[k]) regs[k] = 32'hA5C3_0000 + 32'(k);
        foreach (tx[k]) tx[k] = 8'h00;
        out_bit = 1'b0;
        resp = 1'b0;
        bits = 0;
        framed = 1'b0;
    end
    always @(negedge cs_n_i)
    begin
        bits = 0;
        framed = 1'b1;
    end
    always @(posedge sck_i)
    begin
        if (!cs_n_i && bits < 160)
            rx[bits / 8][7 - bits % 8] = mosi_i;
        bits = bits + 1;
    end
    always @(negedge sck_i)
        if (!cs_n_i && bits < 160)
            out_bit = tx[bits / 8][7 - bits % 8];
    // only a rise after a real frame ends a packet; the reset edge of select does not
    always @(posedge cs_n_i)
    begin
        if (framed)
        begin
            framed = 1'b0;
            if (!resp)
            begin
                err = 8'h00;
                if (rx[0] == `CMD_WRITE_REG && rx[1] < 8'h03)
                    regs[rx[1]] = {rx[7], rx[6], rx[5], rx[4]};
                else if (rx[0] == `CMD_WRITE_REG || rx[1] > 8'h03)
                    err = `ERR_INVALID_REG;
                if (rx[0] != `CMD_WRITE_REG && rx[0] != `CMD_READ_REG)
                    err = ERR_CMD;
                tx[0] = 8'h00;
                tx[1] = rx[0];
                tx[2] = rx[1];
                tx[3] = err;
                for (int k = 0; k < 16; k++)
                    tx[4 + k] = (err == 8'h00 && k < 4) ? regs[rx[1]][8 * k +: 8] : 8'h00;
            end
            resp = !resp;
        end
    end
endmodule // spi_device_model
`default_nettype wire

// ### tb/tb_spi_register_host.sv
`timescale 1ns/10ps
`default_nettype none
`include "spi_host_defs.vh"
module tb_spi_register_host;
    logic         clk_i, reset_n_i, start_i, spi_miso_i, spi_sck_o, spi_cs_n_o;
    logic         spi_mosi_o, busy_o, done_o;
    logic [7:0]   command_i, command_argument_byte_i, echo_command_o, echo_argument_o;
    logic [7:0]   response_error_code_o, previous_error_code_o, prev_err;
    logic [4:0]   request_len_i, response_len_i;
    logic [127:0] write_data_i, read_data_o;
    logic [31:0]  mirror [4];
    int           num_errors, checked;
////////////////////////////////////////////////
    spi_register_host #(.GAP_CYCLES(20)) spi_register_host_inst
    (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .start_i(start_i), .command_i(command_i),
        .command_argument_byte_i(command_argument_byte_i), .request_len_i(request_len_i),
        .response_len_i(response_len_i), .write_data_i(write_data_i),
        .spi_miso_i(spi_miso_i), .spi_sck_o(spi_sck_o), .spi_cs_n_o(spi_cs_n_o),
        .spi_mosi_o(spi_mosi_o), .busy_o(busy_o), .done_o(done_o),
        .echo_command_o(echo_command_o), .echo_argument_o(echo_argument_o),
        .response_error_code_o(response_error_code_o), .read_data_o(read_data_o),
        .previous_error_code_o(previous_error_code_o)
    );
    spi_device_model spi_device_model_inst
    (
        .sck_i(spi_sck_o), .cs_n_i(spi_cs_n_o), .mosi_i(spi_mosi_o), .miso_o(spi_miso_i)
    );
    initial
    begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    function automatic logic [7:0] exp_err(input logic [7:0] c, input logic [7:0] a);
        if (c == `CMD_READ_REG)
            return (a > 8'h03) ? `ERR_INVALID_REG : 8'h00;
        if (c == `CMD_WRITE_REG)
            return (a > 8'h02) ? `ERR_INVALID_REG : 8'h00;
        return 8'h04;
    endfunction
    task automatic check(input string name, input logic [127:0] seen, input logic [127:0] exp);
        checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic give_verdict();
        if (num_errors == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // one transaction; a second start while busy must leave it untouched
    task automatic xact(input logic [7:0] c, input logic [7:0] a, input logic [4:0] rl,
                        input logic [31:0] v);
        logic [7:0] e;
        e = exp_err(c, a);
        command_i = c;
        command_argument_byte_i = a;
        response_len_i = rl;
        request_len_i = (c == `CMD_WRITE_REG) ? 5'd8 : 5'd4;
        write_data_i = {$urandom, $urandom, $urandom, v};
        start_i = 1'b1;
        repeat (2) @(negedge clk_i);
        start_i = 1'b0;
        check("busy", busy_o, 128'(1'b1));
        command_i = ~c;
        start_i = 1'b1;
        @(negedge clk_i);
        start_i = 1'b0;
        for (int n = 0; done_o !== 1'b1; n++)
        begin
            if (n == 20000)
            begin
                num_errors++;
                give_verdict();
            end
            @(negedge clk_i);
        end
        if (c == `CMD_WRITE_REG && e == 8'h00)
            mirror[a[1:0]] = v;
        check("command", echo_command_o, c);
        check("argument", echo_argument_o, a);
        check("error", response_error_code_o, e);
        check("previous", previous_error_code_o, prev_err);
        check("payload", read_data_o, (e != 0 || rl == 4) ? 0 : mirror[a[1:0]]);
        prev_err = e;
    endtask
    initial
    begin
        num_errors = 0;
        checked = 0;
        prev_err = 8'h00;
        reset_n_i = 1'b0;
        start_i = 1'b0;
        command_i = 8'h00;
        command_argument_byte_i = 8'h00;
        request_len_i = 5'd4;
        response_len_i = 5'd4;
        write_data_i = '0;
        void'($urandom(41706));
        foreach (mirror[k]) mirror[k] = 32'hA5C3_0000 + 32'(k);
        repeat (12) @(negedge clk_i);
        reset_n_i = 1'b1;
        repeat (3) @(negedge clk_i);
        for (int k = 0; k < 5; k++)
            xact(`CMD_READ_REG, 8'(k), 5'd8, 32'h0000_0000);
        xact(`CMD_WRITE_REG, 8'h02, 5'd4, 32'hDEAD_BEEF);
        xact(`CMD_READ_REG, 8'h02, 5'd8, 32'h0000_0000);
        xact(`CMD_WRITE_REG, 8'h03, 5'd8, 32'h1234_5678);
        xact(8'h07, 8'h01, 5'd4, 32'h0000_0000);
        repeat (12)
            xact(8'(1 + $urandom % 2), 8'($urandom % 5), ($urandom % 2) ? 5'd20 : 5'd8,
                 $urandom);
        give_verdict();
    end
endmodule // tb_spi_register_host
`default_nettype wire
